// ==== hw/burst_sram_pkg.sv ====
// Constants and types shared by the burst SRAM access logic.
// Assumes one clock in every user and a synchronous active-high reset in every user but the storage array and the bench modules.
// What this block does
// - Processor strobe with chip selected loads address and counter, ignores write and advance.
// - Processor-strobe write takes two cycles; global write at second edge writes word.
// - Byte write enable low with global write high writes only lanes whose select is low.
// - Each lane is eight data bits plus one parity bit, one select each.
// - Data drivers turn off whenever a write cycle is detected.
// - Controller strobe alone with writes active does a one-cycle write, ignores advance.
// - Both strobes low with first select low: only the processor strobe counts.
// - Processor strobe ignored when first chip select is high.
// - Two-bit wraparound counter loads from low address bits on each external start.
// - Order strap low gives linear order, high gives interleaved; strap is static.
// - Burst advance low steps the counter, for reads and writes.
// - Interleaved order xors start value with beat count.
// - Linear order adds one per beat modulo four.
// - Sleep keeps data, takes two cycles in and out, floats data pins.
// - Access pending at sleep entry is dropped.
// - Data pins drive only on a read cycle with output enable low.
// - Three selects qualify selection; a single-select variant uses only the first.
package burst_sram_pkg;
   localparam int LANES = 4;
   localparam int LANE_W = 9;
   localparam int DATA_W = LANES * LANE_W;
   localparam int ADDR_W = 10;
   localparam int DEPTH = 1 << ADDR_W;
   localparam int FIFO_DEPTH = 8;
   localparam int WR_W = ADDR_W + LANES + DATA_W;
   localparam int SLEEP_CYCLES = 2;
   localparam logic [1:0] SLEEP_CNT_MAX = 2'h2;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_READ = 4'h2,
      ST_WRITE = 4'h4,
      ST_SLEEP = 4'h8
   } access_state_t;
endpackage

// ==== hw/sram_array.sv ====
// Storage array with per-lane write and registered read data.
// Assumes a single clock; contents are not reset.
module sram_array (
   // Clock
   input wire logic clk,
   // Write port
   input wire logic wr_en,
   input wire logic [burst_sram_pkg::ADDR_W-1:0] wr_addr,
   input wire logic [burst_sram_pkg::LANES-1:0] wr_lane,
   input wire logic [burst_sram_pkg::DATA_W-1:0] wr_data,
   // Read port
   input wire logic [burst_sram_pkg::ADDR_W-1:0] rd_addr,
   output logic [burst_sram_pkg::DATA_W-1:0] rd_data
);
   // One storage column per lane, so each column has a single writer
   for (genvar l = 0; l < burst_sram_pkg::LANES; l++)
   begin : g_lane
      logic [burst_sram_pkg::LANE_W-1:0] lane_mem [burst_sram_pkg::DEPTH];
      always_ff @(posedge clk)
      begin
         if (wr_en && wr_lane[l])
         begin
            lane_mem[wr_addr] <= wr_data[l*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W];
         end
         rd_data[l*burst_sram_pkg::LANE_W +: burst_sram_pkg::LANE_W] <= lane_mem[rd_addr];
      end
   end
endmodule

// ==== hw/sync_burst_sram_access.sv ====
// Pin-side access logic of a pipelined burst SRAM: strobes, burst counter,
// byte writes, output enable and sleep. Assumes pins are registered
// into the MCLK domain by the caller except sleep, which is synchronised here.
module sync_burst_sram_access (
   // Clock and reset
   input wire logic MCLK,
   input wire logic RESET,
   // Address and selects
   input wire logic [burst_sram_pkg::ADDR_W-1:0] ADDR,
   input wire logic CHIP_SELECT_FIRST_N,
   input wire logic CHIP_SELECT_SECOND,
   input wire logic CHIP_SELECT_THIRD_N,
   input wire logic SINGLE_SELECT,
   // Strobes and burst control
   input wire logic PROC_ADDR_STROBE_N,
   input wire logic CTRL_ADDR_STROBE_N,
   input wire logic BURST_ADVANCE_N,
   input wire logic BURST_ORDER,
   // Write controls
   input wire logic GLOBAL_WRITE_N,
   input wire logic BYTE_WRITE_ENABLE_N,
   input wire logic [burst_sram_pkg::LANES-1:0] BYTE_WRITE_SELECT_N,
   // Output enable and sleep
   input wire logic OUTPUT_ENABLE_N,
   input wire logic SLEEP_REQUEST,
   // Data pins
   input wire logic [burst_sram_pkg::DATA_W-1:0] DATA_IN,
   output logic [burst_sram_pkg::DATA_W-1:0] DATA_OUT,
   output logic DATA_OE,
   // Status
   output logic ASLEEP,
   output logic WRITE_STALL
);
   typedef struct packed {
      burst_sram_pkg::access_state_t st;
      logic [burst_sram_pkg::ADDR_W-1:0] base;
      logic [1:0] start;
      logic [1:0] beat;
      logic first_beat;
      logic proc_started;
      logic sleep_meta;
      logic sleep_sync;
      logic [1:0] sleep_cnt;
      logic [burst_sram_pkg::DATA_W-1:0] dout;
      logic read_valid;
   } ctl_state_t;

   ctl_state_t s;
   ctl_state_t next_s;
   logic selected;
   logic proc_start;
   logic ctrl_start;
   logic deselect;
   logic write_req;
   logic [burst_sram_pkg::LANES-1:0] lanes;
   logic [1:0] low_addr;
   logic [burst_sram_pkg::ADDR_W-1:0] cur_addr;
   logic [burst_sram_pkg::ADDR_W-1:0] wr_addr;
   logic do_write;
   logic f_ready;
   logic f_valid;
   logic [burst_sram_pkg::WR_W-1:0] f_data;
   logic [burst_sram_pkg::ADDR_W-1:0] arr_rd_addr;
   logic [burst_sram_pkg::DATA_W-1:0] arr_rd_data;
   logic write_cycle;

   // Three selects, or only the first in the single-select variant
   assign selected = !CHIP_SELECT_FIRST_N &&
      (SINGLE_SELECT || (CHIP_SELECT_SECOND && !CHIP_SELECT_THIRD_N));
   // Processor strobe wins and needs the first select low
   assign proc_start = !PROC_ADDR_STROBE_N && selected;
   assign ctrl_start = !CTRL_ADDR_STROBE_N && PROC_ADDR_STROBE_N && selected;
   // Controller strobe deselects with any select off, first select high included
   assign deselect = !selected &&
      ((!PROC_ADDR_STROBE_N && !CHIP_SELECT_FIRST_N) || !CTRL_ADDR_STROBE_N);
   // Global write covers all lanes, else byte enable with per-lane selects
   assign lanes = !GLOBAL_WRITE_N ? '1 :
      (!BYTE_WRITE_ENABLE_N ? ~BYTE_WRITE_SELECT_N : '0);
   assign write_req = lanes != '0;

   // Burst address from start bits and beat count
   assign low_addr = BURST_ORDER ? (s.start ^ s.beat) : (s.start + s.beat);
   assign cur_addr = {s.base[burst_sram_pkg::ADDR_W-1:2], low_addr};

   always_comb
   begin
      next_s = s;
      do_write = 1'b0;
      wr_addr = cur_addr;
      next_s.sleep_meta = SLEEP_REQUEST;
      next_s.sleep_sync = s.sleep_meta;
      next_s.read_valid = 1'b0;
      next_s.proc_started = 1'b0;
      if (s.st == burst_sram_pkg::ST_SLEEP)
      begin
         // Exit counts two cycles after the request falls
         if (s.sleep_sync)
         begin
            next_s.sleep_cnt = '0;
         end
         else if (s.sleep_cnt == burst_sram_pkg::SLEEP_CNT_MAX - 2'h1)
         begin
            next_s.st = burst_sram_pkg::ST_IDLE;
            next_s.sleep_cnt = '0;
         end
         else
         begin
            next_s.sleep_cnt = s.sleep_cnt + 2'h1;
         end
      end
      else if (s.sleep_sync)
      begin
         // Pending access dropped on entry
         next_s.sleep_cnt = s.sleep_cnt + 2'h1;
         next_s.st = burst_sram_pkg::ST_IDLE;
         if (s.sleep_cnt == burst_sram_pkg::SLEEP_CNT_MAX - 2'h1)
         begin
            next_s.st = burst_sram_pkg::ST_SLEEP;
            next_s.sleep_cnt = '0;
         end
      end
      else if (proc_start)
      begin
         // Load address and counter, write controls and advance ignored
         next_s.base = ADDR;
         next_s.start = ADDR[1:0];
         next_s.beat = '0;
         next_s.proc_started = 1'b1;
         next_s.st = burst_sram_pkg::ST_READ;
         next_s.read_valid = 1'b1;
      end
      else if (ctrl_start)
      begin
         next_s.base = ADDR;
         next_s.start = ADDR[1:0];
         next_s.beat = '0;
         if (write_req)
         begin
            do_write = 1'b1;
            wr_addr = ADDR;
            next_s.st = burst_sram_pkg::ST_WRITE;
         end
         else
         begin
            next_s.st = burst_sram_pkg::ST_READ;
            next_s.read_valid = 1'b1;
         end
      end
      else if (deselect)
      begin
         next_s.st = burst_sram_pkg::ST_IDLE;
      end
      // Processor strobe with the first select high counts as inactive
      else if ((PROC_ADDR_STROBE_N || CHIP_SELECT_FIRST_N) && CTRL_ADDR_STROBE_N &&
         s.st != burst_sram_pkg::ST_IDLE)
      begin
         // Write at current address, then advance if asked
         if (write_req)
         begin
            do_write = 1'b1;
            next_s.st = burst_sram_pkg::ST_WRITE;
         end
         else
         begin
            next_s.st = burst_sram_pkg::ST_READ;
         end
         if (!BURST_ADVANCE_N && !s.proc_started)
         begin
            next_s.beat = s.beat + 2'h1;
         end
         next_s.read_valid = !write_req;
      end
      if (s.proc_started && PROC_ADDR_STROBE_N && CTRL_ADDR_STROBE_N && !BURST_ADVANCE_N)
      begin
         next_s.beat = s.beat + 2'h1;
      end
      if (s.read_valid)
      begin
         next_s.dout = arr_rd_data;
      end
   end

   // Writes queue in front of the array
   write_fifo #(
      .WIDTH(burst_sram_pkg::WR_W),
      .DEPTH(burst_sram_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clk(MCLK),
      .rst(RESET),
      .in_valid(do_write),
      .in_ready(f_ready),
      .in_data({wr_addr, lanes, DATA_IN}),
      .out_valid(f_valid),
      .out_ready(1'b1),
      .out_data(f_data)
   );

   assign arr_rd_addr = cur_addr;

   sram_array u_array (
      .clk(MCLK),
      .wr_en(f_valid),
      .wr_addr(f_data[burst_sram_pkg::WR_W-1 -: burst_sram_pkg::ADDR_W]),
      .wr_lane(f_data[burst_sram_pkg::DATA_W +: burst_sram_pkg::LANES]),
      .wr_data(f_data[burst_sram_pkg::DATA_W-1:0]),
      .rd_addr(arr_rd_addr),
      .rd_data(arr_rd_data)
   );

   always_ff @(posedge MCLK)
   begin
      if (RESET)
      begin
         s <= '{st: burst_sram_pkg::ST_IDLE, default: '0};
      end
      else
      begin
         s <= next_s;
      end
   end

   // Drivers off on any write cycle, while idle or asleep
   assign write_cycle = s.st == burst_sram_pkg::ST_WRITE;
   assign DATA_OE = (s.st == burst_sram_pkg::ST_READ) && !OUTPUT_ENABLE_N;
   assign DATA_OUT = s.dout;
   assign ASLEEP = s.st == burst_sram_pkg::ST_SLEEP;
   assign WRITE_STALL = !f_ready;

   property p_write_floats;
      @(posedge MCLK) disable iff (RESET) write_cycle |-> !DATA_OE;
   endproperty
   a_write_floats: assert property (p_write_floats) else $error("drive in write");

   property p_proc_loads;
      @(posedge MCLK) disable iff (RESET)
         proc_start && !s.sleep_sync && s.st != burst_sram_pkg::ST_SLEEP
         |=> s.base == $past(ADDR) && s.beat == 2'h0 && s.st == burst_sram_pkg::ST_READ;
   endproperty
   a_proc_loads: assert property (p_proc_loads) else $error("address not loaded");

   property p_sleep_float;
      @(posedge MCLK) disable iff (RESET) ASLEEP |-> !DATA_OE;
   endproperty
   a_sleep_float: assert property (p_sleep_float) else $error("drive while asleep");

   property p_oe_gate;
      @(posedge MCLK) disable iff (RESET) OUTPUT_ENABLE_N |-> !DATA_OE;
   endproperty
   a_oe_gate: assert property (p_oe_gate) else $error("drive with oe high");

   property p_desel;
      @(posedge MCLK) disable iff (RESET)
         deselect && !proc_start && !ctrl_start && !s.sleep_sync &&
         s.st != burst_sram_pkg::ST_SLEEP |=> s.st == burst_sram_pkg::ST_IDLE;
   endproperty
   a_desel: assert property (p_desel) else $error("no deselect");

   property p_linear;
      @(posedge MCLK) disable iff (RESET) !BURST_ORDER |-> low_addr == s.start + s.beat;
   endproperty
   a_linear: assert property (p_linear) else $error("linear order wrong");

   property p_interleave;
      @(posedge MCLK) disable iff (RESET) BURST_ORDER |-> low_addr == (s.start ^ s.beat);
   endproperty
   a_interleave: assert property (p_interleave) else $error("interleave wrong");

   property p_ctrl_write;
      @(posedge MCLK) disable iff (RESET)
         ctrl_start && write_req && !s.sleep_sync && s.st != burst_sram_pkg::ST_SLEEP
         |-> do_write && wr_addr == ADDR;
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("ctrl write missed");

   property p_proc_no_write;
      @(posedge MCLK) disable iff (RESET) proc_start |-> !do_write;
   endproperty
   a_proc_no_write: assert property (p_proc_no_write) else $error("write on start");

   property p_sleep_drop;
      @(posedge MCLK) disable iff (RESET)
         s.sleep_sync && s.st != burst_sram_pkg::ST_SLEEP |-> !do_write;
   endproperty
   a_sleep_drop: assert property (p_sleep_drop) else $error("write in sleep entry");

   property p_advance;
      @(posedge MCLK) disable iff (RESET)
         s.st inside {burst_sram_pkg::ST_READ, burst_sram_pkg::ST_WRITE} && !s.sleep_sync &&
         PROC_ADDR_STROBE_N && CTRL_ADDR_STROBE_N && !BURST_ADVANCE_N
         |=> s.beat == $past(s.beat) + 2'h1;
   endproperty
   a_advance: assert property (p_advance) else $error("burst did not step");

   property p_suspend;
      @(posedge MCLK) disable iff (RESET)
         s.st inside {burst_sram_pkg::ST_READ, burst_sram_pkg::ST_WRITE} && !s.sleep_sync &&
         PROC_ADDR_STROBE_N && CTRL_ADDR_STROBE_N && BURST_ADVANCE_N |=> $stable(s.beat);
   endproperty
   a_suspend: assert property (p_suspend) else $error("burst moved on suspend");

   property p_sleep_entry;
      @(posedge MCLK) disable iff (RESET)
         ($rose(s.sleep_sync) && !ASLEEP) ##1 s.sleep_sync |=> ASLEEP;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("sleep entry late");

   property p_sleep_exit;
      @(posedge MCLK) disable iff (RESET)
         ($fell(s.sleep_sync) && ASLEEP) ##1 !s.sleep_sync |=> !ASLEEP;
   endproperty
   a_sleep_exit: assert property (p_sleep_exit) else $error("sleep exit late");

   c_proc_write: cover property (@(posedge MCLK) proc_start ##1 do_write);
   c_byte_write: cover property (@(posedge MCLK) do_write && GLOBAL_WRITE_N);
   c_suspend: cover property (@(posedge MCLK)
      s.st == burst_sram_pkg::ST_READ && BURST_ADVANCE_N ##1 BURST_ADVANCE_N);
   c_burst: cover property (@(posedge MCLK) ctrl_start ##1 !BURST_ADVANCE_N [*3]);
   c_sleep: cover property (@(posedge MCLK) ASLEEP ##1 !ASLEEP);
endmodule

// ==== hw/write_fifo.sv ====
// Write queue between the pin-side decode and the memory array.
// Assumes a single clock and synchronous active-high reset.
module write_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   typedef struct packed {
      logic [PW-1:0] rd;
      logic [PW-1:0] wr;
      logic [PW:0] count;
   } fifo_state_t;
   fifo_state_t s;
   fifo_state_t next_s;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   assign in_ready = s.count != (PW+1)'(DEPTH);
   assign out_valid = s.count != '0;
   assign out_data = mem[s.rd];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb
   begin
      next_s = s;
      if (push)
      begin
         next_s.wr = s.wr + PW'(1);
      end
      if (pop)
      begin
         next_s.rd = s.rd + PW'(1);
      end
      next_s.count = s.count + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
      if (push)
      begin
         mem[s.wr] <= in_data;
      end
   end

   property p_no_overflow;
      @(posedge clk) disable iff (rst) s.count <= (PW+1)'(DEPTH);
   endproperty
   a_no_overflow: assert property (p_no_overflow) else $error("fifo count above depth");
endmodule

// ==== tb/sram_bus_master.sv ====
// Bus master model: drives strobes, selects, write controls, output
// enable, sleep and write data of the access block.
// Assumes each task is called just after a falling clock edge.
module sram_bus_master (
   // Clock
   input wire logic mclk,
   // Address and selects
   output logic [burst_sram_pkg::ADDR_W-1:0] addr,
   output logic chip_select_first_n,
   output logic chip_select_second,
   output logic chip_select_third_n,
   // Strobes and burst control
   output logic proc_addr_strobe_n,
   output logic ctrl_addr_strobe_n,
   output logic burst_advance_n,
   // Write controls and data
   output logic global_write_n,
   output logic byte_write_enable_n,
   output logic [burst_sram_pkg::LANES-1:0] byte_write_select_n,
   output logic [burst_sram_pkg::DATA_W-1:0] wdata,
   // Output enable and sleep
   output logic output_enable_n,
   output logic sleep_request
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      addr = 10'h000;
      {chip_select_first_n, chip_select_second, chip_select_third_n} = 3'h2;
      {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} = 3'h7;
      {global_write_n, byte_write_enable_n} = 2'h3;
      byte_write_select_n = 4'hF;
      wdata = 36'h0_0000_0000;
      output_enable_n = 1'h0;
      sleep_request = 1'h0;
   end
   // One-cycle write; oe_low keeps the bus enabled to provoke a clash
   task automatic ctrl_write(input logic [9:0] a, input logic [35:0] d,
      input logic gw_n, input logic [3:0] sel_n, input logic oe_low);
      output_enable_n = !oe_low;
      @(negedge mclk);
      addr = a;
      ctrl_addr_strobe_n = 1'h0;
      global_write_n = gw_n;
      byte_write_enable_n = 1'h0;
      byte_write_select_n = sel_n;
      wdata = d;
      @(negedge mclk);
      ctrl_addr_strobe_n = 1'h1;
      {global_write_n, byte_write_enable_n} = 2'h3;
      byte_write_select_n = 4'hF;
      wdata = ~d;
   endtask
   // Strobe cycle carries a decoy word, the real word follows one edge later
   task automatic proc_write(input logic [9:0] a, input logic [35:0] d);
      output_enable_n = 1'h1;
      @(negedge mclk);
      addr = a;
      proc_addr_strobe_n = 1'h0;
      global_write_n = 1'h0;
      wdata = ~d;
      @(negedge mclk);
      proc_addr_strobe_n = 1'h1;
      wdata = d;
      @(negedge mclk);
      global_write_n = 1'h1;
      wdata = ~d;
   endtask
   // Read start; both also lowers the controller strobe and global write
   task automatic start_read(input logic [9:0] a, input logic [2:0] sel, input logic both);
      @(negedge mclk);
      output_enable_n = 1'h0;
      addr = a;
      {chip_select_first_n, chip_select_second, chip_select_third_n} = sel;
      proc_addr_strobe_n = 1'h0;
      ctrl_addr_strobe_n = !both;
      global_write_n = !both;
      @(negedge mclk);
      {chip_select_first_n, chip_select_second, chip_select_third_n} = 3'h2;
      {proc_addr_strobe_n, ctrl_addr_strobe_n, global_write_n} = 3'h7;
   endtask
   task automatic step(input logic adv_n);
      burst_advance_n = adv_n;
      @(negedge mclk);
   endtask
   task automatic enter_sleep();
      @(negedge mclk);
      chip_select_first_n = 1'h1;
      @(negedge mclk);
      sleep_request = 1'h1;
   endtask
   task automatic leave_sleep();
      sleep_request = 1'h0;
      repeat (6) @(negedge mclk);
      chip_select_first_n = 1'h0;
   endtask
endmodule

// ==== tb/sync_burst_sram_access_tb.sv ====
// Self-checking bench for the burst SRAM access block.
// Assumes the package, design files and bus master model come first.
module sync_burst_sram_access_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DW = burst_sram_pkg::DATA_W;
   localparam int LW = burst_sram_pkg::LANE_W;
   logic mclk, reset, burst_order;
   logic [burst_sram_pkg::ADDR_W-1:0] addr;
   logic [burst_sram_pkg::LANES-1:0] byte_write_select_n;
   logic [DW-1:0] wdata, data_out;
   logic chip_select_first_n, chip_select_second, chip_select_third_n;
   logic proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n;
   logic global_write_n, byte_write_enable_n, output_enable_n, sleep_request;
   logic data_oe, asleep, write_stall, single_select;
   int n_fail = 0;
   int tests_run = 0;
   int cycles = 0;
   sram_bus_master m (
      .mclk, .addr, .chip_select_first_n, .chip_select_second, .chip_select_third_n,
      .proc_addr_strobe_n, .ctrl_addr_strobe_n, .burst_advance_n, .global_write_n,
      .byte_write_enable_n, .byte_write_select_n, .wdata, .output_enable_n, .sleep_request
   );
   sync_burst_sram_access DUT (
      .MCLK(mclk), .RESET(reset), .ADDR(addr),
      .CHIP_SELECT_FIRST_N(chip_select_first_n), .CHIP_SELECT_SECOND(chip_select_second),
      .CHIP_SELECT_THIRD_N(chip_select_third_n), .SINGLE_SELECT(single_select),
      .PROC_ADDR_STROBE_N(proc_addr_strobe_n), .CTRL_ADDR_STROBE_N(ctrl_addr_strobe_n),
      .BURST_ADVANCE_N(burst_advance_n), .BURST_ORDER(burst_order),
      .GLOBAL_WRITE_N(global_write_n), .BYTE_WRITE_ENABLE_N(byte_write_enable_n),
      .BYTE_WRITE_SELECT_N(byte_write_select_n), .OUTPUT_ENABLE_N(output_enable_n),
      .SLEEP_REQUEST(sleep_request), .DATA_IN(wdata), .DATA_OUT(data_out),
      .DATA_OE(data_oe), .ASLEEP(asleep), .WRITE_STALL(write_stall)
   );
   initial
   begin
      mclk = 1'h0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_fail++;
         conclude();
      end
   end
   task automatic check(input string what, input logic [DW-1:0] seen, want);
      tests_run++;
      if (seen !== want)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Single read: bus enabled one edge after the start, data one edge later
   task automatic read_word(input logic [9:0] a, input logic [DW-1:0] want, input logic both);
      m.start_read(a, 3'h2, both);
      m.step(1'h1);
      check("read_oe", data_oe, 1'h1);
      m.step(1'h1);
      check("read_data", data_out, want);
   endtask
   task automatic byte_test();
      logic [DW-1:0] d1 = 36'h1_2345_6789;
      logic [DW-1:0] d2 = 36'hE_DCBA_9876;
      logic [DW-1:0] want;
      m.ctrl_write(10'h080, d1, 1'h0, 4'hF, 1'h0);
      check("write_stall", write_stall, 1'h0);
      m.ctrl_write(10'h080, d2, 1'h1, 4'hA, 1'h1);
      check("oe_on_write", data_oe, 1'h0);
      for (int l = 0; l < 4; l++)
         want[l*LW +: LW] = l[0] ? d1[l*LW +: LW] : d2[l*LW +: LW];
      read_word(10'h080, want, 1'h0);
      read_word(10'h080, want, 1'h1);
   endtask
   task automatic burst_test(input logic order);
      logic [1:0] b;
      burst_order = order;
      m.start_read(10'h041, 3'h2, 1'h0);
      m.step(1'h0);
      m.step(1'h0);
      for (int k = 0; k < 4; k++)
      begin
         b = order ? (2'h1 ^ 2'(k)) : (2'h1 + 2'(k));
         check("burst", data_out, 36'h5_A5A5_A500 + 36'(b));
         m.step(k < 1 ? 1'h0 : 1'h1);
      end
      check("suspend", data_out, 36'h5_A5A5_A500 + 36'(b));
   endtask
   // Each case: both strobes, expected drive, selects; last one ignores the strobe
   task automatic deselect_test();
      logic [4:0] cases [4] = '{5'h16, 5'h00, 5'h03, 5'h0E};
      for (int i = 0; i < 4; i++)
      begin
         m.start_read(10'h041, 3'h2, 1'h0);
         m.start_read(10'h041, cases[i][2:0], cases[i][4]);
         m.step(1'h1);
         check("deselect_oe", data_oe, cases[i][3]);
      end
   endtask
   // Single-select variant: second and third selects inactive still select
   task automatic single_test();
      single_select = 1'h1;
      m.start_read(10'h041, 3'h1, 1'h0);
      m.step(1'h1);
      check("single_oe", data_oe, 1'h1);
      m.step(1'h1);
      check("single_data", data_out, 36'h5_A5A5_A501);
      single_select = 1'h0;
   endtask
   task automatic sleep_test();
      m.ctrl_write(10'h300, 36'h9_0F0F_0F0F, 1'h0, 4'hF, 1'h0);
      m.enter_sleep();
      m.step(1'h1);
      repeat (8) @(negedge mclk);
      check("asleep", asleep, 1'h1);
      check("sleep_oe", data_oe, 1'h0);
      m.leave_sleep();
      check("awake", asleep, 1'h0);
      read_word(10'h300, 36'h9_0F0F_0F0F, 1'h0);
   endtask
   initial
   begin
      reset = 1'h1;
      burst_order = 1'h0;
      single_select = 1'h0;
      repeat (6) @(negedge mclk);
      reset = 1'h0;
      check("reset_oe", data_oe, 1'h0);
      check("reset_asleep", asleep, 1'h0);
      byte_test();
      m.proc_write(10'h100, 36'h3_C3C3_3C3C);
      read_word(10'h100, 36'h3_C3C3_3C3C, 1'h0);
      for (int i = 0; i < 4; i++)
         m.ctrl_write(10'h040 + 10'(i), 36'h5_A5A5_A500 + 36'(i), 1'h0, 4'hF, 1'h0);
      burst_test(1'h0);
      burst_test(1'h1);
      deselect_test();
      single_test();
      sleep_test();
      conclude();
   end
endmodule
